// file: src/ducsr_regs.v
// Notes on behaviour
// - Mode field selects normal, echo, local, remote loop
// - Bit 5 RTS control, bit 4 CTS wait
// - Low nibble sets stop length code
// - Upper nibble receiver rate, lower transmitter rate
// - Command 01 enables, 10 disables, 00 keeps
// - Status bits: break, errors, empty, ready, full
// - Config bits 7:4 pick latch or flags
// - Config bits 3:0 pick pin three/two sources
// - Change bits high nibble, levels low nibble
// - Interrupt status bit order as listed
// - Mask uses same positions, one enables
// - Timer preload split into high, low bytes
// - Eight-bit vector given on acknowledge
// - Reset clears status, mask, latch, config; vector 0F
// - Standby stops all but port access, wake 25 us
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`include "ducsr_defs.vh"
module ducsr_regs #(
  parameter WAKE_CYCLES = (`DUCSR_WAKE_NS + `DUCSR_CLK_NS - 1) / `DUCSR_CLK_NS
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire [4:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata,
  input  wire [7:0]  status_a_in,
  input  wire [7:0]  status_b_in,
  input  wire        break_chg_a,
  input  wire        break_chg_b,
  input  wire        counter_ready,
  input  wire        counter_out,
  input  wire        txclk16_a,
  input  wire        txclk1_a,
  input  wire        rxclk1_a,
  input  wire        txclk1_b,
  input  wire        rxclk1_b,
  input  wire [3:0]  input_pins,
  output reg  [7:0]  output_pins,
  output wire        irq,
  output wire [7:0]  irq_vector,
  output wire [15:0] timer_preload,
  output reg  [1:0]  chan_mode_a,
  output reg  [1:0]  chan_mode_b,
  output reg         rts_ctrl_a,
  output reg         rts_ctrl_b,
  output reg         cts_wait_a,
  output reg         cts_wait_b,
  output reg  [3:0]  stop_code_a,
  output reg  [3:0]  stop_code_b,
  output reg  [3:0]  rx_rate_a,
  output reg  [3:0]  tx_rate_a,
  output reg  [3:0]  rx_rate_b,
  output reg  [3:0]  tx_rate_b,
  output reg         tx_en_a,
  output reg         rx_en_a,
  output reg         tx_en_b,
  output reg         rx_en_b,
  output reg         standby,
  output wire        active
);

  ////////////////////////////////////////////////////////////////////////
  // Storage
  reg  [7:0]  mode2_a;        // Channel A second mode register
  reg  [7:0]  mode2_b;        // Channel B second mode register
  reg  [7:0]  rate_a;         // Channel A bit-rate select
  reg  [7:0]  rate_b;         // Channel B bit-rate select
  reg  [7:0]  stat_a;         // Channel A status snapshot
  reg  [7:0]  stat_b;         // Channel B status snapshot
  reg  [7:0]  opcfg;          // Output pin configuration
  reg  [7:0]  oplatch;        // Output port latch
  reg  [7:0]  irq_st;         // Sticky interrupt status
  reg  [7:0]  irq_mask;       // Interrupt mask
  reg  [7:0]  tmr_hi;         // Timer preload high byte
  reg  [7:0]  tmr_lo;         // Timer preload low byte
  reg  [7:0]  ivec;           // Interrupt vector
  reg  [3:0]  in_prev;        // Last seen input level
  reg  [3:0]  in_delta;       // Sticky input change flags
  reg  [15:0] wake_cnt;       // Wake-up countdown
  reg         wake_busy;      // Counting towards active
  reg  [7:0]  next_irq_st;
  reg  [3:0]  next_in_delta;
  wire [3:0]  in_sync;        // Synchronised input levels
  wire [7:0]  irq_events;
  wire        wr_ok;          // Writes allowed outside standby
  wire        rd_chg;         // Read of the input change register
  // Live channel flags; the interrupt side must not wait for the snapshot
  wire        tx_flag_a;      // Channel A transmitter ready
  wire        tx_flag_b;      // Channel B transmitter ready
  wire        rx_flag_a;      // Channel A receiver ready or full
  wire        rx_flag_b;      // Channel B receiver ready or full

  ////////////////////////////////////////////////////////////////////////
  // Decode a two-bit enable command into a new enable state
  function cmd_apply;
    input [1:0] cmd;
    input       cur;
    begin
      case (cmd)
        `DUCSR_CMD_EN:  cmd_apply = 1'b1;
        `DUCSR_CMD_DIS: cmd_apply = 1'b0;
        default:        cmd_apply = cur; // Code 11 is illegal; hold state
      endcase
    end
  endfunction

  // Pick pin source from a two-bit selector
  function sel4;
    input [1:0] s;
    input       i0;
    input       i1;
    input       i2;
    input       i3;
    begin
      case (s)
        `DUCSR_SEL_LATCH: sel4 = i0;
        `DUCSR_SEL_ONE:   sel4 = i1;
        `DUCSR_SEL_TWO:   sel4 = i2;
        default:          sel4 = i3;
      endcase
    end
  endfunction

  // Receiver flag: ready or FIFO full, shared by pins and interrupts
  function rx_flag;
    input [7:0] st;
    begin
      rx_flag = st[`DUCSR_ST_RECEIVER_READY] | st[`DUCSR_ST_RECEIVE_FIFO_FULL];
    end
  endfunction

  // Registers other than the ports and the power state read as zero while clocks are stopped;
  // their contents are not trusted in standby, so software sees nothing stale
  function [7:0] gate_rd;
    input       stby;
    input [7:0] val;
    begin
      gate_rd = stby ? `DUCSR_RST_BYTE : val;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input pins enter through the synchroniser
  ducsr_in_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  (input_pins),
    .dout (in_sync)
  );

  // Standby blocks all but port access and the channel A command misc field
  assign wr_ok  = wr && !standby;
  assign active = !standby && !wake_busy;
  assign rd_chg = rd && (addr == `DUCSR_A_INCHG);

  ////////////////////////////////////////////////////////////////////////
  // Interrupt event sources in status bit order
  // Flags decoded once from the live status inputs
  assign tx_flag_a = status_a_in[`DUCSR_ST_TRANSMITTER_READY];
  assign tx_flag_b = status_b_in[`DUCSR_ST_TRANSMITTER_READY];
  assign rx_flag_a = rx_flag(status_a_in);
  assign rx_flag_b = rx_flag(status_b_in);

  // Held ready levels re-set their bit at once; software masks them instead
  assign irq_events = {|in_delta, break_chg_b, rx_flag_b, tx_flag_b,
                       counter_ready, break_chg_a, rx_flag_a, tx_flag_a};

  // Sticky status: set wins over write-one-to-clear
  always @* begin
    next_irq_st = irq_st;
    if (wr_ok && addr == `DUCSR_A_IRQ_ST) begin
      next_irq_st = irq_st & ~wdata;
    end
    next_irq_st = next_irq_st | irq_events;
  end

  // Masked pairs raise the line
  assign irq = |(irq_st & irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // Input change detection: set beats the clear-on-read
  always @* begin
    next_in_delta = in_delta;
    if (rd_chg) begin
      next_in_delta = 4'h0;
    end
    next_in_delta = next_in_delta | (in_sync ^ in_prev);
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes and state; all control registers reset to defined values
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode2_a  <= `DUCSR_RST_BYTE;
      mode2_b  <= `DUCSR_RST_BYTE;
      rate_a   <= `DUCSR_RST_BYTE;
      rate_b   <= `DUCSR_RST_BYTE;
      stat_a   <= `DUCSR_RST_BYTE;
      stat_b   <= `DUCSR_RST_BYTE;
      opcfg    <= `DUCSR_RST_BYTE;
      oplatch  <= `DUCSR_RST_BYTE;
      irq_st   <= `DUCSR_RST_BYTE;
      irq_mask <= `DUCSR_RST_BYTE;
      tmr_hi   <= `DUCSR_RST_BYTE;
      tmr_lo   <= `DUCSR_RST_BYTE;
      ivec     <= `DUCSR_RST_VEC;
      in_prev  <= 4'h0;
      in_delta <= 4'h0;
      tx_en_a  <= 1'b0;
      rx_en_a  <= 1'b0;
      tx_en_b  <= 1'b0;
      rx_en_b  <= 1'b0;
      standby  <= 1'b0;
      wake_busy <= 1'b0;
      wake_cnt <= 16'h0000;
    end else begin
      // Previous level kept to spot each edge on the pins
      in_prev  <= in_sync;
      in_delta <= next_in_delta;
      // Status tracks the channels whenever standby is low, wake countdown included; frozen in standby,
      // which trades fresh status for quiet power, so reread after wake
      if (!standby) begin
        stat_a <= status_a_in;
        stat_b <= status_b_in;
        irq_st <= next_irq_st;
      end
      // Control writes; dropped while the clocks are stopped
      if (wr_ok) begin
        case (addr)
          `DUCSR_A_MODE2_A:  mode2_a  <= wdata;
          `DUCSR_A_MODE2_B:  mode2_b  <= wdata;
          `DUCSR_A_RATE_A:   rate_a   <= wdata;
          `DUCSR_A_RATE_B:   rate_b   <= wdata;
          `DUCSR_A_OPCFG:    opcfg    <= wdata;
          `DUCSR_A_IRQ_MASK: irq_mask <= wdata;
          `DUCSR_A_TMR_HI:   tmr_hi   <= wdata;
          `DUCSR_A_TMR_LO:   tmr_lo   <= wdata;
          `DUCSR_A_IRQ_VEC:  ivec     <= wdata;
          `DUCSR_A_CMD_B: begin
            tx_en_b <= cmd_apply(wdata[`DUCSR_TXCMD_HI:`DUCSR_TXCMD_LO], tx_en_b);
            rx_en_b <= cmd_apply(wdata[`DUCSR_RXCMD_HI:`DUCSR_RXCMD_LO], rx_en_b);
          end
          `DUCSR_A_CMD_A: begin
            tx_en_a <= cmd_apply(wdata[`DUCSR_TXCMD_HI:`DUCSR_TXCMD_LO], tx_en_a);
            rx_en_a <= cmd_apply(wdata[`DUCSR_RXCMD_HI:`DUCSR_RXCMD_LO], rx_en_a);
          end
          default: begin
            // Latch and interrupt status are written elsewhere; other addresses hold no writable state
          end
        endcase
      end
      // Output port latch stays writable in standby
      if (wr && addr == `DUCSR_A_OPLATCH) begin
        oplatch <= wdata;
      end
      // Standby entry and exit through channel A command misc field
      if (wr && addr == `DUCSR_A_CMD_A) begin
        if (wdata[`DUCSR_MISC_HI:`DUCSR_MISC_LO] == `DUCSR_MISC_STANDBY) begin
          standby <= 1'b1;
        end else if (standby && wdata[`DUCSR_MISC_HI:`DUCSR_MISC_LO] == `DUCSR_MISC_ACTIVE) begin
          standby   <= 1'b0;
          wake_busy <= 1'b1;
          wake_cnt  <= WAKE_CYCLES[15:0] - 16'h0001;
        end
      end
      // Wake countdown; active is reported exactly at the limit, WAKE_CYCLES cycles after the command.
      // The count starts only once standby has dropped, so a second
      // wake command during the count simply does nothing
      if (wake_busy && !standby) begin
        if (wake_cnt == 16'h0000) begin
          wake_busy <= 1'b0;
        end else begin
          wake_cnt <= wake_cnt - 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field breakout to the channel logic
  always @* begin
    chan_mode_a = mode2_a[`DUCSR_CHMODE_HI:`DUCSR_CHMODE_LO];
    chan_mode_b = mode2_b[`DUCSR_CHMODE_HI:`DUCSR_CHMODE_LO];
    rts_ctrl_a  = mode2_a[`DUCSR_RTS_BIT];
    rts_ctrl_b  = mode2_b[`DUCSR_RTS_BIT];
    cts_wait_a  = mode2_a[`DUCSR_CTS_BIT];
    cts_wait_b  = mode2_b[`DUCSR_CTS_BIT];
    stop_code_a = mode2_a[`DUCSR_STOP_HI:`DUCSR_STOP_LO];
    stop_code_b = mode2_b[`DUCSR_STOP_HI:`DUCSR_STOP_LO];
    // Receiver and transmitter rates are chosen independently
    rx_rate_a   = rate_a[`DUCSR_RXRATE_HI:`DUCSR_RXRATE_LO];
    tx_rate_a   = rate_a[`DUCSR_TXRATE_HI:`DUCSR_TXRATE_LO];
    rx_rate_b   = rate_b[`DUCSR_RXRATE_HI:`DUCSR_RXRATE_LO];
    tx_rate_b   = rate_b[`DUCSR_TXRATE_HI:`DUCSR_TXRATE_LO];
  end

  assign irq_vector    = ivec;
  assign timer_preload = {tmr_hi, tmr_lo};

  ////////////////////////////////////////////////////////////////////////
  // Output pins, registered so no glitches reach the pads
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      output_pins <= `DUCSR_RST_BYTE;
    end else begin
      // Upper pins show either the latch or the snapshot flags
      output_pins[7] <= opcfg[7] ? stat_b[`DUCSR_ST_TRANSMITTER_READY] : oplatch[7];
      output_pins[6] <= opcfg[6] ? stat_a[`DUCSR_ST_TRANSMITTER_READY] : oplatch[6];
      output_pins[5] <= opcfg[5] ? rx_flag(stat_b) : oplatch[5];
      output_pins[4] <= opcfg[4] ? rx_flag(stat_a) : oplatch[4];
      // Pins three and two pick among latch, timer and channel clocks
      output_pins[3] <= sel4(opcfg[3:2], oplatch[3], counter_out, txclk1_b, rxclk1_b);
      output_pins[2] <= sel4(opcfg[1:0], oplatch[2], txclk16_a, txclk1_a, rxclk1_a);
      // Lowest pins always follow the latch
      output_pins[1:0] <= oplatch[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port: data one cycle after the strobe; unmapped reads give zero
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= `DUCSR_RST_BYTE;
    end else if (rd) begin
      case (addr)
        // Channel registers, hidden in standby
        `DUCSR_A_MODE2_A:  rdata <= gate_rd(standby, mode2_a);
        `DUCSR_A_MODE2_B:  rdata <= gate_rd(standby, mode2_b);
        `DUCSR_A_STATUS_A: rdata <= gate_rd(standby, stat_a);
        `DUCSR_A_STATUS_B: rdata <= gate_rd(standby, stat_b);
        // Input port stays readable in standby
        `DUCSR_A_INCHG:    rdata <= {in_delta, in_sync};
        `DUCSR_A_IRQ_ST:   rdata <= gate_rd(standby, irq_st);
        `DUCSR_A_IRQ_VEC:  rdata <= gate_rd(standby, ivec);
        // Power state so software can poll the wake-up
        `DUCSR_A_PWR:      rdata <= {6'h00, wake_busy, standby};
        default:           rdata <= `DUCSR_RST_BYTE;
      endcase
    end else begin
      rdata <= `DUCSR_RST_BYTE;
    end
  end
endmodule // ducsr_regs

// file: src/ducsr_defs.vh
`ifndef DUCSR_DEFS_VH
`define DUCSR_DEFS_VH
// Register addresses (chosen map, one byte register per address)
`define DUCSR_A_MODE2_A    5'h00
`define DUCSR_A_RATE_A     5'h01
`define DUCSR_A_STATUS_A   5'h02
`define DUCSR_A_CMD_A      5'h03
`define DUCSR_A_MODE2_B    5'h04
`define DUCSR_A_RATE_B     5'h05
`define DUCSR_A_STATUS_B   5'h06
`define DUCSR_A_CMD_B      5'h07
`define DUCSR_A_OPCFG      5'h08
`define DUCSR_A_INCHG      5'h09
`define DUCSR_A_IRQ_ST     5'h0A
`define DUCSR_A_IRQ_MASK   5'h0B
`define DUCSR_A_TMR_HI     5'h0C
`define DUCSR_A_TMR_LO     5'h0D
`define DUCSR_A_IRQ_VEC    5'h0E
`define DUCSR_A_OPLATCH    5'h0F
`define DUCSR_A_PWR        5'h10
// Field positions
`define DUCSR_CHMODE_HI    7
`define DUCSR_CHMODE_LO    6
`define DUCSR_RTS_BIT      5
`define DUCSR_CTS_BIT      4
`define DUCSR_STOP_HI      3
`define DUCSR_STOP_LO      0
`define DUCSR_RXRATE_HI    7
`define DUCSR_RXRATE_LO    4
`define DUCSR_TXRATE_HI    3
`define DUCSR_TXRATE_LO    0
`define DUCSR_ST_TRANSMITTER_READY     2
`define DUCSR_ST_RECEIVE_FIFO_FULL     1
`define DUCSR_ST_RECEIVER_READY     0
`define DUCSR_TXCMD_HI     3
`define DUCSR_TXCMD_LO     2
`define DUCSR_RXCMD_HI     1
`define DUCSR_RXCMD_LO     0
`define DUCSR_MISC_HI      7
`define DUCSR_MISC_LO      4
// Encodings
`define DUCSR_CMD_KEEP     2'h0
`define DUCSR_CMD_EN       2'h1
`define DUCSR_CMD_DIS      2'h2
`define DUCSR_MODE_NORMAL  2'h0
`define DUCSR_MODE_ECHO    2'h1
`define DUCSR_MODE_LLOOP   2'h2
`define DUCSR_MODE_RLOOP   2'h3
`define DUCSR_MISC_STANDBY 4'hE
`define DUCSR_MISC_ACTIVE  4'hF
`define DUCSR_SEL_LATCH    2'h0
`define DUCSR_SEL_ONE      2'h1
`define DUCSR_SEL_TWO      2'h2
// Reset values
`define DUCSR_RST_BYTE     8'h00
`define DUCSR_RST_VEC      8'h0F
// Wake time
`define DUCSR_WAKE_NS      25000
`define DUCSR_CLK_NS       10
`endif

// file: src/ducsr_in_sync.v
// Three-stage input synchroniser; a change is taken once stages two and three agree
module ducsr_in_sync #(
  parameter WIDTH = 4
) (
  input  wire             clk,
  input  wire             rstn,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] s1; // Metastability stage, read only by s2
  reg [WIDTH-1:0] s2;
  reg [WIDTH-1:0] s3;
  genvar i;

  // Shift chain
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= {WIDTH{1'b0}};
      s2 <= {WIDTH{1'b0}};
      s3 <= {WIDTH{1'b0}};
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Per-bit acceptance when two later stages agree
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          dout[i] <= 1'b0;
        end else if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  endgenerate
endmodule // ducsr_in_sync

// file: dv/ducsr_regs_monitor.sv
module ducsr_regs_monitor #(
  parameter WAKE_CYCLES = 5
) (
  input wire        clk,
  input wire        rstn,
  input wire [4:0]  addr,
  input wire [7:0]  wdata,
  input wire        wr,
  input wire        rd,
  input wire [7:0]  rdata,
  input wire        irq,
  input wire [7:0]  irq_vector,
  input wire [15:0] timer_preload,
  input wire [7:0]  output_pins,
  input wire [1:0]  chan_mode_a,
  input wire        rts_ctrl_a,
  input wire        cts_wait_a,
  input wire [3:0]  stop_code_a,
  input wire [3:0]  rx_rate_b,
  input wire [3:0]  tx_rate_b,
  input wire        tx_en_a,
  input wire        rx_en_a,
  input wire        standby,
  input wire        active
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain, so clocking and disable are given once
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  a_reset_values: assert property ($rose(rstn) |-> irq_vector == 8'h0F && output_pins == 8'h00 && !irq)
    else $error("reset values wrong");
  a_read_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  a_mode_fields: assert property (wr && addr == 5'h00 && !standby |=>
    {chan_mode_a, rts_ctrl_a, cts_wait_a, stop_code_a} == $past(wdata)) else $error("mode fields wrong");
  a_rate_split: assert property (wr && addr == 5'h05 && !standby |=> {rx_rate_b, tx_rate_b} == $past(wdata))
    else $error("rate nibbles wrong");
  a_cmd_enable: assert property (wr && addr == 5'h03 && !standby && wdata[3:2] == 2'h1 |=> tx_en_a)
    else $error("transmitter not enabled");
  a_cmd_keep: assert property (wr && addr == 5'h03 && !standby && wdata[1:0] == 2'h0 |=> $stable(rx_en_a))
    else $error("receiver changed on keep");
  a_timer_high: assert property (wr && addr == 5'h0C && !standby |=> timer_preload[15:8] == $past(wdata))
    else $error("timer high byte wrong");
  a_vector_write: assert property (wr && addr == 5'h0E && !standby |=> irq_vector == $past(wdata))
    else $error("vector not written");
  a_standby_enter: assert property (wr && addr == 5'h03 && wdata[7:4] == 4'hE |=> standby && !active)
    else $error("standby not entered");
  // The wake bound fits the short simulation count only
  a_wake_bound: assert property ($fell(standby) |-> ##[0:10] active)
    else $error("wake took too long");
endmodule // ducsr_regs_monitor

bind ducsr_regs ducsr_regs_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) ducsr_regs_monitor_inst (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
  .irq_vector(irq_vector), .timer_preload(timer_preload), .output_pins(output_pins),
  .chan_mode_a(chan_mode_a), .rts_ctrl_a(rts_ctrl_a), .cts_wait_a(cts_wait_a), .stop_code_a(stop_code_a),
  .rx_rate_b(rx_rate_b), .tx_rate_b(tx_rate_b), .tx_en_a(tx_en_a), .rx_en_a(rx_en_a),
  .standby(standby), .active(active));

// file: dv/ducsr_far_end.sv
// Channel and timer side: registered levels, events, clock sources and pins
module ducsr_far_end (
  input  wire       clk,
  input  wire       rstn,
  input  wire [7:0] set_st_a,  // Wanted channel A status levels
  input  wire [7:0] set_st_b,  // Wanted channel B status levels
  input  wire [2:0] set_ev,    // Event request {break B, counter, break A}
  input  wire [5:0] set_src,   // Pin source levels
  input  wire [3:0] set_pins,  // Input pin levels
  output reg  [7:0] st_a,      // Status A to the block
  output reg  [7:0] st_b,      // Status B to the block
  output reg  [2:0] ev,        // Event pulses, one cycle per request cycle
  output reg  [5:0] src,       // Clock and counter sources
  output reg  [3:0] pins       // Input pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // Everything leaves a flop, as real channel logic would
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {st_a, st_b, ev, src, pins} <= 29'h0;
    end else begin
      {st_a, st_b, ev, src, pins} <= {set_st_a, set_st_b, set_ev, set_src, set_pins};
    end
  end
endmodule // ducsr_far_end

// file: dv/ducsr_regs_bench.sv
`include "ducsr_defs.vh"
module ducsr_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, wr, rd;
  logic [4:0] addr;
  logic [7:0] wdata, set_st_a, set_st_b;
  logic [2:0] set_ev;
  logic [5:0] set_src;
  logic [3:0] set_pins;
  int err_total, comparisons, cycles;
  wire [7:0] st_a, st_b, rdata, output_pins, irq_vector;
  wire [2:0] ev;
  wire [5:0] src;
  wire [3:0] pins, stop_code_a, rx_rate_a, tx_rate_a, rx_rate_b, tx_rate_b;
  wire [15:0] timer_preload;
  wire [1:0] chan_mode_a;
  wire irq, standby, active, rts_ctrl_a, cts_wait_a, tx_en_a, rx_en_a, tx_en_b, rx_en_b;
  ////////////////////////////////////////////////////////////////////////////////
  ducsr_far_end ducsr_far_end_inst (.clk(clk), .rstn(rstn), .set_st_a(set_st_a), .set_st_b(set_st_b),
    .set_ev(set_ev), .set_src(set_src), .set_pins(set_pins), .st_a(st_a), .st_b(st_b), .ev(ev), .src(src),
    .pins(pins));
  // Short wake count keeps the standby scenario brief
  ducsr_regs #(.WAKE_CYCLES(5)) ducsr_regs_inst (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .status_a_in(st_a), .status_b_in(st_b), .break_chg_a(ev[0]), .break_chg_b(ev[2]),
    .counter_ready(ev[1]), .counter_out(src[5]), .txclk16_a(src[4]), .txclk1_a(src[3]), .rxclk1_a(src[2]),
    .txclk1_b(src[1]), .rxclk1_b(src[0]), .input_pins(pins), .output_pins(output_pins), .irq(irq),
    .irq_vector(irq_vector), .timer_preload(timer_preload), .chan_mode_a(chan_mode_a), .chan_mode_b(),
    .rts_ctrl_a(rts_ctrl_a), .rts_ctrl_b(), .cts_wait_a(cts_wait_a), .cts_wait_b(), .stop_code_a(stop_code_a),
    .stop_code_b(), .rx_rate_a(rx_rate_a), .tx_rate_a(tx_rate_a), .rx_rate_b(rx_rate_b), .tx_rate_b(tx_rate_b),
    .tx_en_a(tx_en_a), .rx_en_a(rx_en_a), .tx_en_b(tx_en_b), .rx_en_b(rx_en_b), .standby(standby), .active(active));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling far above the expected run
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t value mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus cycles: one strobe cycle each, effects checked once they have landed
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_mode;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {i[1:0], i[0], ~i[1], 4'(i * 5)};
      wr_reg(`DUCSR_A_MODE2_A, d);
      chk({chan_mode_a, rts_ctrl_a, cts_wait_a, stop_code_a}, d);
    end
    wr_reg(`DUCSR_A_MODE2_B, ~d);
    chk({chan_mode_a, rts_ctrl_a, cts_wait_a, stop_code_a}, d);
    wr_reg(`DUCSR_A_RATE_A, 8'h5A);
    wr_reg(`DUCSR_A_RATE_B, 8'hC3);
    chk({rx_rate_a, tx_rate_a, rx_rate_b, tx_rate_b}, 16'h5AC3);
  endtask
  task automatic t_cmd;
    wr_reg(`DUCSR_A_CMD_A, 8'h05);
    chk({tx_en_a, rx_en_a, tx_en_b, rx_en_b}, 4'hC);
    wr_reg(`DUCSR_A_CMD_A, 8'h00);
    chk({tx_en_a, rx_en_a}, 2'h3);
    wr_reg(`DUCSR_A_CMD_A, 8'h08);
    chk({tx_en_a, rx_en_a}, 2'h1);
    wr_reg(`DUCSR_A_CMD_A, 8'h02);
    chk({tx_en_a, rx_en_a}, 2'h0);
  endtask
  // Ready levels feed the interrupt status, so levels are dropped before clearing
  task automatic t_status;
    @(posedge clk) set_st_a <= 8'hA5;
    set_st_b <= 8'h3C;
    wait_cyc(3);
    rd_chk(`DUCSR_A_STATUS_A, 8'hA5);
    rd_chk(`DUCSR_A_STATUS_B, 8'h3C);
    @(posedge clk) set_st_a <= 8'h00;
    set_st_b <= 8'h00;
    wait_cyc(3);
    rd_chk(`DUCSR_A_IRQ_ST, 8'h13);
    wr_reg(`DUCSR_A_IRQ_ST, 8'hFF);
    rd_chk(`DUCSR_A_IRQ_ST, 8'h00);
    rd_chk(5'h1F, 8'h00);
  endtask
  task automatic t_irq;
    @(posedge clk) set_ev <= 3'h7;
    @(posedge clk) set_ev <= 3'h0;
    wait_cyc(3);
    rd_chk(`DUCSR_A_IRQ_ST, 8'h4C);
    chk(irq, 1'b0);
    wr_reg(`DUCSR_A_IRQ_MASK, 8'h40);
    chk(irq, 1'b1);
    wr_reg(`DUCSR_A_IRQ_ST, 8'h40);
    chk(irq, 1'b0);
    rd_chk(`DUCSR_A_IRQ_ST, 8'h0C);
    wr_reg(`DUCSR_A_IRQ_ST, 8'h0C);
  endtask
  task automatic t_inchg;
    @(posedge clk) set_pins <= 4'h5;
    wait_cyc(6);
    rd_chk(`DUCSR_A_INCHG, 8'h55);
    rd_chk(`DUCSR_A_INCHG, 8'h05);
    rd_chk(`DUCSR_A_IRQ_ST, 8'h80);
    wr_reg(`DUCSR_A_IRQ_ST, 8'h80);
  endtask
  task automatic op_try(input logic [7:0] cfg, input logic [5:0] s, input logic [7:0] e);
    @(posedge clk) set_src <= s;
    wr_reg(`DUCSR_A_OPCFG, cfg);
    wait_cyc(3);
    chk(output_pins, e);
  endtask
  task automatic t_ports;
    wr_reg(`DUCSR_A_TMR_HI, 8'h12);
    wr_reg(`DUCSR_A_TMR_LO, 8'h34);
    chk(timer_preload, 16'h1234);
    wr_reg(`DUCSR_A_IRQ_VEC, 8'hA7);
    rd_chk(`DUCSR_A_IRQ_VEC, 8'hA7);
    @(posedge clk) set_st_a <= 8'h01;
    op_try(8'h15, 6'h30, 8'h1C);
    op_try(8'h15, 6'h20, 8'h18);
    op_try(8'hFA, 6'h0A, 8'h1C);
    op_try(8'h0F, 6'h05, 8'h0C);
    op_try(8'h00, 6'h3F, 8'h00);
  endtask
  // Standby: only latch writes, the command A misc field, and input change and power state reads still work
  task automatic t_standby;
    int n;
    wr_reg(`DUCSR_A_CMD_A, 8'hE0);
    chk({standby, active}, 2'h2);
    wr_reg(`DUCSR_A_IRQ_VEC, 8'h55);
    chk(irq_vector, 8'hA7);
    rd_chk(`DUCSR_A_IRQ_VEC, 8'h00);
    rd_chk(`DUCSR_A_INCHG, 8'h05);
    wr_reg(`DUCSR_A_OPLATCH, 8'hC3);
    wait_cyc(2);
    chk(output_pins, 8'hC3);
    wr_reg(`DUCSR_A_CMD_A, 8'hF0);
    n = 0;
    while (active !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    chk(n <= 6, 1'b1);
    wr_reg(`DUCSR_A_IRQ_VEC, 8'h5A);
    chk(irq_vector, 8'h5A);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    {rstn, wr, rd, addr, wdata, set_st_a, set_st_b, set_ev, set_src, set_pins} = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk({irq_vector, output_pins}, 16'h0F00);
    chk({irq, active, standby}, 3'h2);
    rd_chk(`DUCSR_A_STATUS_A, 8'h00);
    rd_chk(`DUCSR_A_IRQ_ST, 8'h00);
    t_mode();
    t_cmd();
    t_status();
    t_irq();
    t_inchg();
    t_ports();
    t_standby();
    finish_test();
  end
endmodule // ducsr_regs_bench
